//--- design/stm_top.sv
/*
  supply and temperature monitor control: axi4-lite registers, start and
  periodic sequencing, status capture, threshold flags and interrupt.
  assumes the analog sensors answer a one-cycle request with a one-cycle
  done pulse carrying all three band codes, synchronous to aclk.
*/
`timescale 1ns/1ps

// Summary of operation
// - periodic interval is period field times 16 ms, field one is 16 ms
// - periodic bit one repeats measurement each period, zero runs once
// - writing one to start launches monitoring; bit self-clears, zero ignored
// - undervoltage threshold at bits 14:12 of threshold register, reset 111
// - voltage codes are eight bands from above +9% down below -16.5%
// - overvoltage threshold at bits 10:8, reset 000, same voltage bands
// - overtemperature threshold at bits 2:0, reset 111, temperature bands
// - io supply code read-only in bits 14:12 of supply status, reset 000
// - analog supply code read-only in bits 10:8 of supply status, reset 000
// - undervoltage indication output for general-purpose pin routing
module stm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        aclk_en,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sense_req,
  input  wire logic        sense_done,
  input  wire logic [2:0]  sense_temp,
  input  wire logic [2:0]  sense_io_supply,
  input  wire logic [2:0]  sense_analog_supply,
  output logic             undervoltage_ind,
  output logic             overvoltage_ind,
  output logic             overtemp_ind,
  output logic             irq
);

  logic [3:0]        period_reg;
  logic              periodic_reg;
  logic              start_reg;
  logic [2:0]        uv_reg;
  logic [2:0]        ov_reg;
  logic [2:0]        ot_reg;
  logic [2:0]        temp_reg;
  logic [2:0]        io_reg;
  logic [2:0]        ana_reg;
  logic [3:0]        ev_reg;
  logic [3:0]        mask_reg;
  logic              aw_held;
  logic              w_held;
  logic [15:0]       awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  stm_pkg::stm_state_t state_reg;
  logic [23:0]       step_cnt_reg;
  logic [3:0]        steps_left_reg;
  logic              uv_hit;
  logic              ov_hit;
  logic              ot_hit;
  logic              wr_fire;
  logic              wr_ok;
  logic [11:0]       wr_idx;
  logic [11:0]       rd_idx;
  logic              rd_ok;
  logic [31:0]       rd_word;
  logic [3:0]        ev_set;
  logic [3:0]        clr_mask;
  logic              start_wr;
  logic              step_done;

  localparam logic [23:0] STEP_LAST = 24'(stm_pkg::STEP_CYCLES - 1);
  // write address and data are captured independently, then joined
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx        = awaddr_reg[stm_pkg::ADDR_W-1:2];
  assign wr_ok         = awaddr_reg[1:0] == 2'h0 && awaddr_reg[15:stm_pkg::ADDR_W] == 2'h0
                         && wr_idx >= stm_pkg::IDX_PERIOD_CFG && wr_idx <= stm_pkg::IDX_EVENT_MASK;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      awaddr_reg <= 16'h0000;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end
    else if (aclk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held    <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held    <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // write response, slverr for an unmapped or misaligned address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= stm_pkg::RESP_OKAY;
    end
    else if (aclk_en)
    begin
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? stm_pkg::RESP_OKAY : stm_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers, low two byte lanes only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_reg   <= stm_pkg::PERIOD_RST;
      periodic_reg <= stm_pkg::PERIODIC_RST;
      uv_reg       <= stm_pkg::UV_RST;
      ov_reg       <= stm_pkg::OV_RST;
      ot_reg       <= stm_pkg::OT_RST;
      mask_reg     <= stm_pkg::MASK_RST;
    end
    else if (aclk_en && wr_fire && wr_ok)
    begin
      unique case (wr_idx)
        stm_pkg::IDX_PERIOD_CFG:
          if (wstrb_reg[0])
            period_reg <= wdata_reg[stm_pkg::PERIOD_LSB +: 4];
        stm_pkg::IDX_MODE_CFG:
          if (wstrb_reg[0])
            periodic_reg <= wdata_reg[stm_pkg::MODE_PERIODIC];
        stm_pkg::IDX_THRESH_CFG:
        begin
          if (wstrb_reg[1])
          begin
            uv_reg <= wdata_reg[stm_pkg::UV_LSB +: 3];
            ov_reg <= wdata_reg[stm_pkg::OV_LSB +: 3];
          end
          if (wstrb_reg[0])
            ot_reg <= wdata_reg[stm_pkg::OT_LSB +: 3];
        end
        stm_pkg::IDX_EVENT_MASK:
          if (wstrb_reg[0])
            mask_reg <= wdata_reg[3:0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // start bit: set by a written one, cleared when the run launches
  assign start_wr = wr_fire && wr_ok && wr_idx == stm_pkg::IDX_MODE_CFG && wstrb_reg[0]
                    && wdata_reg[stm_pkg::MODE_START];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_reg <= 1'b0;
    else if (aclk_en)
    begin
      if (start_wr)
        start_reg <= 1'b1;
      else if (state_reg == stm_pkg::STM_IDLE)
        start_reg <= 1'b0;
    end
  end

  // sequencer: request, wait for codes, then idle or count the period
  assign step_done = step_cnt_reg == STEP_LAST;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg      <= stm_pkg::STM_IDLE;
      step_cnt_reg   <= 24'h000000;
      steps_left_reg <= 4'h0;
      sense_req      <= 1'b0;
    end
    else if (aclk_en)
    begin
      sense_req <= 1'b0;
      unique case (state_reg)
        stm_pkg::STM_IDLE:
          if (start_reg)
          begin
            sense_req <= 1'b1;
            state_reg <= stm_pkg::STM_MEASURE;
          end
        stm_pkg::STM_MEASURE:
          if (sense_done)
          begin
            step_cnt_reg <= 24'h000000;
            // zero period would be illegal; run it as one step
            steps_left_reg <= (period_reg == 4'h0) ? 4'h1 : period_reg;
            state_reg <= periodic_reg ? stm_pkg::STM_WAIT : stm_pkg::STM_IDLE;
          end
        stm_pkg::STM_WAIT:
          if (!periodic_reg)
            state_reg <= stm_pkg::STM_IDLE;
          else if (step_done)
          begin
            step_cnt_reg <= 24'h000000;
            if (steps_left_reg == 4'h1)
            begin
              sense_req <= 1'b1;
              state_reg <= stm_pkg::STM_MEASURE;
            end
            else
              steps_left_reg <= steps_left_reg - 4'h1;
          end
          else
            step_cnt_reg <= step_cnt_reg + 24'h000001;
        default: state_reg <= stm_pkg::STM_IDLE;
      endcase
    end
  end

  // status codes captured together from one completed measurement
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      temp_reg <= stm_pkg::CODE_RST;
      io_reg   <= stm_pkg::CODE_RST;
      ana_reg  <= stm_pkg::CODE_RST;
    end
    else if (aclk_en && state_reg == stm_pkg::STM_MEASURE && sense_done)
    begin
      temp_reg <= sense_temp;
      io_reg   <= sense_io_supply;
      ana_reg  <= sense_analog_supply;
    end
  end

  // threshold compares; higher voltage code is lower voltage
  stm_cmp u_cmp_uv_io (.code(io_reg), .limit(uv_reg), .above(1'b1), .beyond(uv_hit));
  stm_cmp u_cmp_ov_io (.code(io_reg), .limit(ov_reg), .above(1'b0), .beyond(ov_hit));
  stm_cmp u_cmp_ot    (.code(temp_reg), .limit(ot_reg), .above(1'b1), .beyond(ot_hit));

  // indications follow the latest io supply and temperature codes, not the analog supply code; undervoltage also feeds gpio routing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      undervoltage_ind <= 1'b0;
      overvoltage_ind  <= 1'b0;
      overtemp_ind     <= 1'b0;
    end
    else if (aclk_en)
    begin
      undervoltage_ind <= uv_hit;
      overvoltage_ind  <= ov_hit;
      overtemp_ind     <= ot_hit;
    end
  end

  // sticky events set on completion; write one to clear, set wins
  assign ev_set[stm_pkg::EV_UV]   = state_reg == stm_pkg::STM_MEASURE && sense_done
                                    && (sense_io_supply > uv_reg || sense_analog_supply > uv_reg);
  assign ev_set[stm_pkg::EV_OV]   = state_reg == stm_pkg::STM_MEASURE && sense_done
                                    && (sense_io_supply < ov_reg || sense_analog_supply < ov_reg);
  assign ev_set[stm_pkg::EV_OT]   = state_reg == stm_pkg::STM_MEASURE && sense_done && sense_temp > ot_reg;
  assign ev_set[stm_pkg::EV_DONE] = state_reg == stm_pkg::STM_MEASURE && sense_done;
  assign clr_mask = (wr_fire && wr_ok && wr_idx == stm_pkg::IDX_EVENT_STAT && wstrb_reg[0])
                    ? wdata_reg[3:0] : 4'h0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ev_reg <= 4'h0;
    else if (aclk_en)
      ev_reg <= (ev_reg & ~clr_mask) | ev_set;
  end

  // interrupt level: any unmasked sticky event
  assign irq = |(ev_reg & mask_reg);
  // read path
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[stm_pkg::ADDR_W-1:2];
  assign rd_ok         = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[15:stm_pkg::ADDR_W] == 2'h0
                         && rd_idx >= stm_pkg::IDX_PERIOD_CFG && rd_idx <= stm_pkg::IDX_EVENT_MASK;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (rd_idx)
      stm_pkg::IDX_PERIOD_CFG:  rd_word[3:0] = period_reg;
      stm_pkg::IDX_MODE_CFG:    rd_word[15:0] = stm_pkg::MODE_RSVD | {14'h0000, periodic_reg, start_reg};
      stm_pkg::IDX_THRESH_CFG:  rd_word[15:0] = {1'b0, uv_reg, 1'b0, ov_reg, 5'h00, ot_reg};
      stm_pkg::IDX_TEMP_STAT:   rd_word[2:0] = temp_reg;
      stm_pkg::IDX_SUPPLY_STAT: rd_word[15:0] = {1'b0, io_reg, 1'b0, ana_reg, 8'h00};
      stm_pkg::IDX_EVENT_STAT:  rd_word[3:0] = ev_reg;
      stm_pkg::IDX_EVENT_MASK:  rd_word[3:0] = mask_reg;
      default:                  rd_word = 32'h0000_0000;
    endcase
  end

  // read answer registered; unmapped reads give zero with slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= stm_pkg::RESP_OKAY;
    end
    else if (aclk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? stm_pkg::RESP_OKAY : stm_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- design/stm_pkg.sv
/*
  constants for the supply and temperature monitor control block:
  register indices, field positions, reset values, timing counts.
  assumes a 100 MHz clock and an axi4-lite register bus with 32-bit data.
*/
package stm_pkg;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [11:0] IDX_PERIOD_CFG   = 12'h480;
  localparam logic [11:0] IDX_MODE_CFG     = 12'h481;
  localparam logic [11:0] IDX_THRESH_CFG   = 12'h482;
  localparam logic [11:0] IDX_TEMP_STAT    = 12'h483;
  localparam logic [11:0] IDX_SUPPLY_STAT  = 12'h484;
  localparam logic [11:0] IDX_EVENT_STAT   = 12'h485;
  localparam logic [11:0] IDX_EVENT_MASK   = 12'h486;
  localparam int          ADDR_W           = 14;

  // field positions
  localparam int PERIOD_LSB   = 0;
  localparam int MODE_START   = 0;
  localparam int MODE_PERIODIC = 1;
  localparam int UV_LSB       = 12;
  localparam int OV_LSB       = 8;
  localparam int OT_LSB       = 0;
  localparam int TEMP_LSB     = 0;
  localparam int IO_LSB       = 12;
  localparam int ANA_LSB      = 8;
  localparam int EV_UV        = 0;
  localparam int EV_OV        = 1;
  localparam int EV_OT        = 2;
  localparam int EV_DONE      = 3;

  // reset values
  localparam logic [3:0] PERIOD_RST   = 4'h2;
  localparam logic       PERIODIC_RST = 1'b1;
  localparam logic [2:0] UV_RST       = 3'h7;
  localparam logic [2:0] OV_RST       = 3'h0;
  localparam logic [2:0] OT_RST       = 3'h7;
  localparam logic [2:0] CODE_RST     = 3'h0;
  localparam logic [3:0] MASK_RST     = 4'h0;
  localparam logic [15:0] MODE_RSVD   = 16'h00a0;

  // timing: one period step is 16 ms
  localparam int CLK_HZ        = 100_000_000;
  localparam int STEP_MS       = 16;
  localparam int STEP_CYCLES   = CLK_HZ / 1000 * STEP_MS;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    STM_IDLE    = 2'b00,
    STM_MEASURE = 2'b01,
    STM_WAIT    = 2'b10
  } stm_state_t;

endpackage

//--- design/stm_cmp.sv
/*
  compares one measured band code against one threshold code.
  assumes codes grow as the quantity falls (voltage) or rises (temperature).
*/
`timescale 1ns/1ps
module stm_cmp (
  input  wire logic [2:0] code,
  input  wire logic [2:0] limit,
  input  wire logic       above,
  output logic            beyond
);

  // above: flag when code exceeds limit, else when below it
  assign beyond = above ? (code > limit) : (code < limit);

endmodule

//--- testbench/stm_asserts.sv
/*
  port assertions for the monitor control block.
  assumes it is bound to stm_top and that aclk_en stays high in the bench.
*/
`timescale 1ns/1ps
module stm_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        aclk_en,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sense_req,
  input wire logic        undervoltage_ind,
  input wire logic        overvoltage_ind,
  input wire logic        overtemp_ind,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both halves of a write taken on one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && aclk_en;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready && aclk_en;
  endsequence

  // bus answers and holding
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_rd_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid) else $error("read not answered");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_b_released: assert property (s_axi_bvalid && s_axi_bready && aclk_en |=> !s_axi_bvalid)
    else $error("write answer stuck");
  a_r_released: assert property (s_axi_rvalid && s_axi_rready && aclk_en |=> !s_axi_rvalid)
    else $error("read answer stuck");
  a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // one request pulse per launch
  a_req_single: assert property (sense_req |=> !sense_req [*2]) else $error("request pulse too long");
  // everything quiet after reset
  a_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0) !aresetn && aclk_en |=>
    !s_axi_bvalid && !s_axi_rvalid && !sense_req && !irq && !undervoltage_ind && !overvoltage_ind
    && !overtemp_ind) else $error("outputs busy after reset");
endmodule

bind stm_top stm_asserts u_chk (.aclk, .aresetn, .aclk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .sense_req, .undervoltage_ind, .overvoltage_ind, .overtemp_ind, .irq);

//--- testbench/stm_top_tb.sv
/*
  self-checking bench for stm_top: register rows, one single run,
  events with interrupt, stray done, periodic run, second reset.
  assumes the bench drives every port itself; aclk_en stays high.
*/
`timescale 1ns/1ps
module stm_top_tb;
  typedef struct {
    bit          wr;
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } stm_row_t;
  logic        aclk, aresetn, aclk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        sense_req, sense_done, undervoltage_ind, overvoltage_ind, overtemp_ind, irq;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, g;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  sense_temp, sense_io_supply, sense_analog_supply;
  int          miscompares, comparisons, n;
  stm_row_t    rows [9] = '{'{1'h0, 16'h1200, 32'h0, 32'h2}, '{1'h0, 16'h1204, 32'h0, 32'ha2},
    '{1'h0, 16'h1208, 32'h0, 32'h7007}, '{1'h0, 16'h120c, 32'h0, 32'h0}, '{1'h0, 16'h1210, 32'h0, 32'h0},
    '{1'h1, 16'h1208, 32'h3105, 32'h3105}, '{1'h1, 16'h120c, 32'h7, 32'h0},
    '{1'h1, 16'h1200, 32'hf, 32'hf}, '{1'h1, 16'h1218, 32'hf, 32'hf}};

  stm_top dut (.aclk, .aresetn, .aclk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense_req,
    .sense_done, .sense_temp, .sense_io_supply, .sense_analog_supply, .undervoltage_ind, .overvoltage_ind,
    .overtemp_ind, .irq);

  // 100 mhz clock
  always #5 aclk = ~aclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic summarize;
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // write: address and data offered together, ready sampled before each edge
  task automatic axw(input logic [15:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (!tb);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    while (!tr);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    axr(a, g, r);
    chk(g, e);
  endtask

  // wait at falling edges for the measurement request
  task automatic wait_req;
    n = 0;
    while (!sense_req && n < 200)
    begin
      @(negedge aclk);
      n++;
    end
  endtask

  // one-cycle done carrying three codes; lines then show other values
  task automatic done_pulse(input logic [2:0] t, input logic [2:0] io, input logic [2:0] an);
    @(posedge aclk);
    sense_done <= 1'b1;
    sense_temp <= t;
    sense_io_supply <= io;
    sense_analog_supply <= an;
    @(posedge aclk);
    sense_done <= 1'b0;
    sense_temp <= ~t;
    sense_io_supply <= ~io;
    sense_analog_supply <= ~an;
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    summarize;
  end

  // main sequence
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sense_done} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sense_temp, sense_io_supply, sense_analog_supply} = '0;
    aclk_en = 1'b1;
    s_axi_wstrb = 4'hf;
    miscompares = 0;
    comparisons = 0;
    do_reset;
    // register rows: reset values, read-write and read-only fields
    foreach (rows[i])
    begin
      if (rows[i].wr) axw(rows[i].a, rows[i].d, r);
      axr(rows[i].a, g, r);
      chk(g, rows[i].e);
      chk(32'(r), 32'(stm_pkg::RESP_OKAY));
    end
    // unmapped place
    axw(16'h1300, 32'h1, r);
    chk(32'(r), 32'(stm_pkg::RESP_SLVERR));
    axr(16'h1300, g, r);
    chk(32'(r), 32'(stm_pkg::RESP_SLVERR));
    // single run: start with periodic off, start bit clears itself
    axw(16'h1200, 32'h1, r);
    axw(16'h1204, 32'h1, r);
    wait_req;
    chk(32'(sense_req), 32'h1);
    done_pulse(3'h6, 3'h4, 3'h2);
    rdchk(16'h1204, 32'(stm_pkg::MODE_RSVD));
    rdchk(16'h120c, 32'h6);
    rdchk(16'h1210, 32'h4200);
    rdchk(16'h1214, 32'hd);
    chk(32'(undervoltage_ind), 32'h1);
    chk(32'(overvoltage_ind), 32'h0);
    chk(32'(overtemp_ind), 32'h1);
    chk(32'(irq), 32'h1);
    // stray done outside a measurement leaves codes alone
    done_pulse(3'h1, 3'h1, 3'h1);
    rdchk(16'h120c, 32'h6);
    // clear one event, mask, clear the rest
    axw(16'h1214, 32'h4, r);
    rdchk(16'h1214, 32'h9);
    axw(16'h1218, 32'h0, r);
    chk(32'(irq), 32'h0);
    axw(16'h1218, 32'hf, r);
    chk(32'(irq), 32'h1);
    axw(16'h1214, 32'hf, r);
    rdchk(16'h1214, 32'h0);
    chk(32'(irq), 32'h0);
    // periodic run: no early second request; clearing the bit ends it
    axw(16'h1204, 32'h3, r);
    wait_req;
    chk(32'(sense_req), 32'h1);
    done_pulse(3'h2, 3'h2, 3'h2);
    n = 0;
    repeat (500)
    begin
      @(negedge aclk);
      if (sense_req !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
    rdchk(16'h1204, 32'(stm_pkg::MODE_RSVD) | 32'h2);
    axw(16'h1204, 32'h0, r);
    axw(16'h1204, 32'h1, r);
    wait_req;
    chk(32'(sense_req), 32'h1);
    done_pulse(3'h2, 3'h2, 3'h2);
    rdchk(16'h1214, 32'h8);
    chk(32'(undervoltage_ind), 32'h0);
    chk(32'(overtemp_ind), 32'h0);
    // second reset restores defaults
    do_reset;
    rdchk(16'h1208, 32'h7007);
    rdchk(16'h1210, 32'h0);
    rdchk(16'h120c, 32'h0);
    summarize;
  end
endmodule
